// File: verilog/swbd_device.sv
`timescale 1ns/1ps
// Function
// - Halted-group commands only while halted.
// - Halted commands: registers, single step, resume.
// - Non-intrusive commands work while program runs.
// - Non-intrusive: memory and own status access.
// - Host starts every bit with falling edge.
// - All fields shift most significant bit first.
// - Sync request returns a timed low pulse.
// - Wire level during reset selects halted start.
// - Undriven pulled-up wire starts user program.
// - Background command wakes from stop or wait.
// - One address breakpoint comparator.
// - Enabled controller keeps oscillator running.
// - Watchdog held off while halted.
// - Own registers reachable only over the wire.
// - Low phases end with driven speedup pulse.
// - Link usable any time without reset.
// - Debug clock selects bus or local clock.
// - Nominal bit period is sixteen ticks.
// - 512 idle ticks abort current command.
// - Host bits sampled ten ticks after start.
// - Sent zero held low thirteen ticks.
module swbd_device (
  input wire logic clk,
  input wire logic ce,
  input wire logic nrst,
  swbd_link_if.device link,
  input wire logic altTick,
  input wire logic stopMode,
  input wire logic waitMode,
  output logic wakeReq,
  output logic oscKeep,
  output logic wdogHold,
  output logic haltedActive,
  output logic goPulse,
  output logic stepPulse,
  input wire logic stepDone,
  input wire logic fetchValid,
  input wire logic [15:0] fetchAddr,
  output logic bkptHit,
  output logic memReq,
  output logic memWe,
  output logic [15:0] memAddr,
  output logic [7:0] memWdata,
  input wire logic memAck,
  input wire logic [7:0] memRdata,
  output logic regWe,
  output logic [2:0] regIdx,
  output logic [15:0] regWdata,
  input wire logic [15:0] regRdata
);
  typedef enum logic [1:0] {
    ST_RX = 2'b00,
    ST_EXEC = 2'b01,
    ST_MEM = 2'b10,
    ST_TX = 2'b11
  } swbd_state_type;

  swbd_state_type state_ff;
  logic pinMeta_ff;
  logic pinSync_ff;
  logic pinPrev_ff;
  logic strapLow_ff;
  logic rstDone_ff;
  logic [9:0] bitCnt_ff;
  logic bitLive_ff;
  logic bitIsTx_ff;
  logic [9:0] idleCnt_ff;
  logic [9:0] lowCnt_ff;
  logic syncOn_ff;
  logic [9:0] syncCnt_ff;
  logic [5:0] rxCnt_ff;
  logic [23:0] rxShift_ff;
  logic [7:0] cmd_ff;
  logic [23:0] txShift_ff;
  logic [4:0] txLeft_ff;
  logic [15:0] bkpt_ff;
  logic enable_ff;
  logic bkptEn_ff;
  logic clkSel_ff;
  logic halted_ff;
  logic stepping_ff;
  logic go_ff;
  logic step_ff;
  logic wake_ff;
  logic hit_ff;
  logic memReq_ff;
  logic memWe_ff;
  logic [15:0] memAddr_ff;
  logic [7:0] memWdata_ff;
  logic regWe_ff;
  logic [2:0] regIdx_ff;
  logic [15:0] regWdata_ff;
  logic dTick;
  logic fallHost;
  logic sampleNow;
  logic txAdv;
  logic timeout;
  logic syncHit;
  logic execNow;
  logic [7:0] newCmd;
  logic [7:0] status;
  logic txLow;
  logic txHigh;
  logic syncLow;
  logic syncHigh;

  // ==========================================================================
  // Command decode helpers.
  function automatic logic isRegCmd(input logic [7:0] c, input logic [7:0] base);
    isRegCmd = ((c & swbd_pkg::CMD_REG_MASK) == base);
  endfunction : isRegCmd

  function automatic logic [5:0] hostBits(input logic [7:0] c);
    if (c == swbd_pkg::CMD_WRITE_CONTROL) begin
      hostBits = 6'h08;
    end else if (c == swbd_pkg::CMD_WRITE_BYTE || c == swbd_pkg::CMD_WRITE_BYTE_WS) begin
      hostBits = 6'h18;
    end else if (c == swbd_pkg::CMD_READ_BYTE || c == swbd_pkg::CMD_READ_BYTE_WS ||
                 c == swbd_pkg::CMD_WRITE_BKPT || isRegCmd(c, swbd_pkg::CMD_WRITE_REG)) begin
      hostBits = 6'h10;
    end else begin
      hostBits = 6'h00;
    end
  endfunction : hostBits

  function automatic logic [4:0] devBits(input logic [7:0] c, input logic h);
    if (c == swbd_pkg::CMD_READ_STATUS || c == swbd_pkg::CMD_READ_BYTE ||
        c == swbd_pkg::CMD_WRITE_BYTE_WS) begin
      devBits = 5'h08;
    end else if (c == swbd_pkg::CMD_READ_BYTE_WS || c == swbd_pkg::CMD_READ_LAST ||
                 c == swbd_pkg::CMD_READ_BKPT || (h && isRegCmd(c, swbd_pkg::CMD_READ_REG))) begin
      devBits = 5'h10;
    end else begin
      devBits = 5'h00;
    end
  endfunction : devBits

  // ==========================================================================
  // Wire synchroniser, edges and the selected debug tick.
  always_ff @(posedge clk) begin
    if (ce) begin
      pinMeta_ff <= link.level;
      pinSync_ff <= pinMeta_ff;
      pinPrev_ff <= pinSync_ff;
    end
  end

  assign dTick = clkSel_ff ? altTick : 1'b1;
  assign fallHost = pinPrev_ff & ~pinSync_ff & ~syncOn_ff & ~(bitLive_ff & bitIsTx_ff);
  assign sampleNow = bitLive_ff & dTick & ~fallHost & (bitCnt_ff == swbd_pkg::SAMPLE_TICK);
  assign txAdv = bitLive_ff & bitIsTx_ff & dTick & ~fallHost &
                 (bitCnt_ff == swbd_pkg::TX_ADV_TICK);
  assign timeout = dTick & ~fallHost & (idleCnt_ff == swbd_pkg::TIMEOUT_LAST) &
                   (state_ff != ST_RX || rxCnt_ff != 6'h00);
  assign syncHit = ~pinPrev_ff & pinSync_ff & (lowCnt_ff == swbd_pkg::SYNC_MIN_LOW);
  assign execNow = (state_ff == ST_EXEC);
  assign newCmd = {rxShift_ff[6:0], pinSync_ff};

  // ==========================================================================
  // Bit period timer and idle timeout counter.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bitCnt_ff <= '0;
      bitLive_ff <= 1'b0;
      bitIsTx_ff <= 1'b0;
      idleCnt_ff <= '0;
    end else if (ce) begin
      if (fallHost) begin
        bitCnt_ff <= '0;
        bitLive_ff <= 1'b1;
        bitIsTx_ff <= (state_ff == ST_TX);
        idleCnt_ff <= '0;
      end else if (dTick) begin
        if (bitLive_ff) begin
          bitCnt_ff <= bitCnt_ff + 10'h001;
        end
        if (bitCnt_ff == swbd_pkg::BIT_TICKS) begin
          bitLive_ff <= 1'b0;
        end
        if (idleCnt_ff != swbd_pkg::TIMEOUT_LAST) begin
          idleCnt_ff <= idleCnt_ff + 10'h001;
        end
      end
    end
  end

  // ==========================================================================
  // Sync request detection and timed response pulse.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lowCnt_ff <= '0;
      syncOn_ff <= 1'b0;
      syncCnt_ff <= '0;
    end else if (ce) begin
      if (pinSync_ff || syncOn_ff) begin
        lowCnt_ff <= '0;
      end else if (dTick && lowCnt_ff != swbd_pkg::SYNC_MIN_LOW) begin
        lowCnt_ff <= lowCnt_ff + 10'h001;
      end
      if (syncHit) begin
        syncOn_ff <= 1'b1;
        syncCnt_ff <= '0;
      end else if (syncOn_ff && dTick) begin
        syncCnt_ff <= syncCnt_ff + 10'h001;
        if (syncCnt_ff == swbd_pkg::SYNC_LOW_END) begin
          syncOn_ff <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Pin drive.
  assign txLow = bitLive_ff & bitIsTx_ff & ~txShift_ff[23] &
                 (bitCnt_ff < swbd_pkg::ZERO_LOW_TICKS);
  assign txHigh = bitLive_ff & bitIsTx_ff & (bitCnt_ff == (txShift_ff[23] ?
                  swbd_pkg::ONE_SPEEDUP_TICK : swbd_pkg::ZERO_LOW_TICKS));
  assign syncLow = syncOn_ff & (syncCnt_ff >= swbd_pkg::SYNC_GAP_TICKS) &
                   (syncCnt_ff < swbd_pkg::SYNC_LOW_END);
  assign syncHigh = syncOn_ff & (syncCnt_ff == swbd_pkg::SYNC_LOW_END);
  assign link.devOe = txLow | txHigh | syncLow | syncHigh;
  assign link.devOut = txHigh | syncHigh;

  // ==========================================================================
  // Status byte.
  always_comb begin
    status = 8'h00;
    status[swbd_pkg::SS_ENABLE] = enable_ff;
    status[swbd_pkg::SS_HALTED] = halted_ff;
    status[swbd_pkg::SS_BKPT_EN] = bkptEn_ff;
    status[swbd_pkg::SS_CLK_SEL] = clkSel_ff;
    status[swbd_pkg::SS_LOW_POWER] = stopMode | waitMode;
  end

  // ==========================================================================
  // Command sequencer; a sync request or timeout returns it to ST_RX from any state.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= ST_RX;
      rxCnt_ff <= '0;
      rxShift_ff <= '0;
      cmd_ff <= '0;
      txShift_ff <= '0;
      txLeft_ff <= '0;
      bkpt_ff <= '0;
      memReq_ff <= 1'b0;
      memWe_ff <= 1'b0;
      memAddr_ff <= '0;
      memWdata_ff <= '0;
      regWe_ff <= 1'b0;
      regIdx_ff <= '0;
      regWdata_ff <= '0;
    end else if (ce) begin
      regWe_ff <= 1'b0;
      if (syncHit || timeout) begin
        state_ff <= ST_RX;
        rxCnt_ff <= '0;
        memReq_ff <= 1'b0;
      end else begin
        unique case (state_ff)
          ST_RX: begin
            if (sampleNow) begin
              rxShift_ff <= {rxShift_ff[22:0], pinSync_ff};
              rxCnt_ff <= rxCnt_ff + 6'h01;
              if (rxCnt_ff == swbd_pkg::CMD_LAST_BIT) begin
                cmd_ff <= newCmd;
                regIdx_ff <= newCmd[2:0];
              end
              if ((rxCnt_ff == swbd_pkg::CMD_LAST_BIT && hostBits(newCmd) == 6'h00) ||
                  (rxCnt_ff > swbd_pkg::CMD_LAST_BIT &&
                   rxCnt_ff == swbd_pkg::CMD_LAST_BIT + hostBits(cmd_ff))) begin
                state_ff <= ST_EXEC;
                rxCnt_ff <= '0;
              end
            end
          end
          ST_EXEC: begin
            txLeft_ff <= devBits(cmd_ff, halted_ff);
            state_ff <= (devBits(cmd_ff, halted_ff) != 5'h00) ? ST_TX : ST_RX;
            unique case (cmd_ff)
              swbd_pkg::CMD_READ_STATUS: txShift_ff <= {status, 16'h0000};
              swbd_pkg::CMD_READ_BKPT: txShift_ff <= {bkpt_ff, 8'h00};
              swbd_pkg::CMD_WRITE_BKPT: bkpt_ff <= rxShift_ff[15:0];
              swbd_pkg::CMD_READ_BYTE, swbd_pkg::CMD_READ_BYTE_WS: begin
                memReq_ff <= 1'b1;
                memWe_ff <= 1'b0;
                memAddr_ff <= rxShift_ff[15:0];
                state_ff <= ST_MEM;
              end
              swbd_pkg::CMD_READ_LAST: begin
                memReq_ff <= 1'b1;
                memWe_ff <= 1'b0;
                state_ff <= ST_MEM;
              end
              swbd_pkg::CMD_WRITE_BYTE, swbd_pkg::CMD_WRITE_BYTE_WS: begin
                memReq_ff <= 1'b1;
                memWe_ff <= 1'b1;
                memAddr_ff <= rxShift_ff[23:8];
                memWdata_ff <= rxShift_ff[7:0];
                state_ff <= ST_MEM;
              end
              default: begin
                if (halted_ff && isRegCmd(cmd_ff, swbd_pkg::CMD_READ_REG)) begin
                  txShift_ff <= {regRdata, 8'h00};
                end
                if (halted_ff && isRegCmd(cmd_ff, swbd_pkg::CMD_WRITE_REG)) begin
                  regWe_ff <= 1'b1;
                  regWdata_ff <= rxShift_ff[15:0];
                end
              end
            endcase
          end
          ST_MEM: begin
            if (memAck) begin
              memReq_ff <= 1'b0;
              txLeft_ff <= devBits(cmd_ff, halted_ff);
              state_ff <= (devBits(cmd_ff, halted_ff) != 5'h00) ? ST_TX : ST_RX;
              if (cmd_ff == swbd_pkg::CMD_READ_BYTE) begin
                txShift_ff <= {memRdata, 16'h0000};
              end else begin
                txShift_ff <= {status, memRdata, 8'h00};
              end
            end
          end
          ST_TX: begin
            if (txAdv) begin
              txShift_ff <= {txShift_ff[22:0], 1'b0};
              txLeft_ff <= txLeft_ff - 5'h01;
              if (txLeft_ff == 5'h01) begin
                state_ff <= ST_RX;
              end
            end
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Control bits, written by the wire command; enable_ff is also loaded from the reset strap.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      enable_ff <= 1'b0;
      bkptEn_ff <= 1'b0;
      clkSel_ff <= 1'b0;
    end else if (ce) begin
      if (!rstDone_ff) begin
        enable_ff <= strapLow_ff;
      end else if (execNow && cmd_ff == swbd_pkg::CMD_WRITE_CONTROL) begin
        enable_ff <= rxShift_ff[swbd_pkg::SS_ENABLE];
        bkptEn_ff <= rxShift_ff[swbd_pkg::SS_BKPT_EN];
        clkSel_ff <= rxShift_ff[swbd_pkg::SS_CLK_SEL];
      end
    end
  end

  // ==========================================================================
  // Reset strap capture.
  always_ff @(posedge clk) begin
    if (ce && !nrst) begin
      strapLow_ff <= ~pinSync_ff;
    end
  end

  // ==========================================================================
  // Halt, run, single step, breakpoint and wake control.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rstDone_ff <= 1'b0;
      halted_ff <= 1'b0;
      stepping_ff <= 1'b0;
      go_ff <= 1'b0;
      step_ff <= 1'b0;
      wake_ff <= 1'b0;
      hit_ff <= 1'b0;
    end else if (ce) begin
      go_ff <= 1'b0;
      step_ff <= 1'b0;
      wake_ff <= 1'b0;
      hit_ff <= 1'b0;
      if (!rstDone_ff) begin
        rstDone_ff <= 1'b1;
        halted_ff <= strapLow_ff;
      end else if (execNow && cmd_ff == swbd_pkg::CMD_BACKGROUND && enable_ff) begin
        halted_ff <= 1'b1;
        stepping_ff <= 1'b0;
        wake_ff <= stopMode | waitMode;
      end else if (execNow && halted_ff && cmd_ff == swbd_pkg::CMD_GO) begin
        halted_ff <= 1'b0;
        go_ff <= 1'b1;
      end else if (execNow && halted_ff && cmd_ff == swbd_pkg::CMD_STEP) begin
        halted_ff <= 1'b0;
        stepping_ff <= 1'b1;
        step_ff <= 1'b1;
      end else if (stepping_ff && stepDone) begin
        halted_ff <= 1'b1;
        stepping_ff <= 1'b0;
      end else if (enable_ff && bkptEn_ff && fetchValid && !halted_ff &&
                   fetchAddr == bkpt_ff) begin
        halted_ff <= 1'b1;
        hit_ff <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Outputs.
  assign haltedActive = halted_ff;
  assign wdogHold = halted_ff;
  assign oscKeep = enable_ff;
  assign wakeReq = wake_ff;
  assign goPulse = go_ff;
  assign stepPulse = step_ff;
  assign bkptHit = hit_ff;
  assign memReq = memReq_ff;
  assign memWe = memWe_ff;
  assign memAddr = memAddr_ff;
  assign memWdata = memWdata_ff;
  assign regWe = regWe_ff;
  assign regIdx = regIdx_ff;
  assign regWdata = regWdata_ff;

endmodule : swbd_device

// File: include/swbd_pkg.sv
package swbd_pkg;

  // ==========================================================================
  // Bit timing in debug clock ticks.
  localparam logic [9:0] BIT_TICKS = 10'h010;
  localparam logic [9:0] SAMPLE_TICK = 10'h00a;
  localparam logic [9:0] ZERO_LOW_TICKS = 10'h00d;
  localparam logic [9:0] ONE_SPEEDUP_TICK = 10'h007;
  localparam logic [9:0] TX_ADV_TICK = ZERO_LOW_TICKS + 10'h001;
  localparam logic [9:0] TIMEOUT_TICKS = 10'h200;
  localparam logic [9:0] TIMEOUT_LAST = TIMEOUT_TICKS - 10'h001;
  localparam logic [9:0] SYNC_MIN_LOW = 10'h080;
  localparam logic [9:0] SYNC_GAP_TICKS = 10'h010;
  localparam logic [9:0] SYNC_PULSE_TICKS = 10'h080;
  localparam logic [9:0] SYNC_LOW_END = SYNC_GAP_TICKS + SYNC_PULSE_TICKS;

  // ==========================================================================
  // Host side timing in host clock cycles.
  localparam logic [9:0] HOST_PERIOD = 10'h014;
  localparam logic [9:0] HOST_ONE_LOW = 10'h004;
  localparam logic [9:0] HOST_RX_LOW = 10'h002;
  localparam logic [9:0] HOST_SYNC_LAT = 10'h002;
  localparam logic [9:0] HOST_RX_SAMPLE = SAMPLE_TICK + HOST_SYNC_LAT;
  localparam logic [9:0] HOST_SYNC_HOLD = 10'h0a0;
  localparam logic [9:0] HOST_SYNC_WAIT = 10'h190;

  // ==========================================================================
  // Command codes.
  localparam logic [7:0] CMD_BACKGROUND = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'he4;
  localparam logic [7:0] CMD_WRITE_CONTROL = 8'hc4;
  localparam logic [7:0] CMD_READ_BYTE = 8'he0;
  localparam logic [7:0] CMD_READ_BYTE_WS = 8'he1;
  localparam logic [7:0] CMD_READ_LAST = 8'he8;
  localparam logic [7:0] CMD_WRITE_BYTE = 8'hc0;
  localparam logic [7:0] CMD_WRITE_BYTE_WS = 8'hc1;
  localparam logic [7:0] CMD_READ_BKPT = 8'he2;
  localparam logic [7:0] CMD_WRITE_BKPT = 8'hc2;
  localparam logic [7:0] CMD_GO = 8'h08;
  localparam logic [7:0] CMD_STEP = 8'h10;
  localparam logic [7:0] CMD_REG_MASK = 8'hf8;
  localparam logic [7:0] CMD_READ_REG = 8'h68;
  localparam logic [7:0] CMD_WRITE_REG = 8'h48;
  localparam logic [5:0] CMD_LAST_BIT = 6'h07;

  // ==========================================================================
  // Status and control byte layout.
  localparam int SS_ENABLE = 7;
  localparam int SS_HALTED = 6;
  localparam int SS_BKPT_EN = 5;
  localparam int SS_CLK_SEL = 2;
  localparam int SS_LOW_POWER = 1;

  // ==========================================================================
  // Host request kinds.
  localparam logic [1:0] KIND_SEND = 2'h0;
  localparam logic [1:0] KIND_RECV = 2'h1;
  localparam logic [1:0] KIND_SYNC = 2'h2;

endpackage : swbd_pkg

// File: include/swbd_link_if.sv
`timescale 1ns/1ps
interface swbd_link_if;
  logic hostOut;
  logic hostOe;
  logic devOut;
  logic devOe;
  logic level;

  // ==========================================================================
  // Pulled-up wire: any enabled low drive wins.
  assign level = ((hostOe && !hostOut) || (devOe && !devOut)) ? 1'b0 : 1'b1;

  modport device(input level, output devOut, output devOe);
  modport host(input level, output hostOut, output hostOe);
endinterface : swbd_link_if

// File: verilog/swbd_host.sv
`timescale 1ns/1ps
module swbd_host (
  input wire logic clk,
  input wire logic ce,
  input wire logic nrst,
  swbd_link_if.host link,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [1:0] reqKind,
  input wire logic [4:0] reqBits,
  input wire logic [23:0] reqData,
  output logic respValid,
  output logic [23:0] respData
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_BIT = 2'b01,
    H_HOLD = 2'b10,
    H_MEAS = 2'b11
  } swbd_hstate_type;

  swbd_hstate_type state_ff;
  logic [9:0] cnt_ff;
  logic [4:0] bitsLeft_ff;
  logic sending_ff;
  logic [23:0] shift_ff;
  logic [23:0] rx_ff;
  logic respValid_ff;
  logic [23:0] resp_ff;
  logic pinMeta_ff;
  logic pinSync_ff;
  logic [9:0] lowLen;
  logic driveLow;
  logic driveHigh;

  // ==========================================================================
  // Pin synchroniser.
  always_ff @(posedge clk) begin
    if (ce) begin
      pinMeta_ff <= link.level;
      pinSync_ff <= pinMeta_ff;
    end
  end

  // ==========================================================================
  // Every bit starts with our falling edge; speedup pulse ends each low phase.
  assign lowLen = !sending_ff ? swbd_pkg::HOST_RX_LOW :
                  (shift_ff[23] ? swbd_pkg::HOST_ONE_LOW : swbd_pkg::ZERO_LOW_TICKS);
  assign driveLow = (state_ff == H_BIT && cnt_ff < lowLen) ||
                    (state_ff == H_HOLD && cnt_ff < swbd_pkg::HOST_SYNC_HOLD);
  assign driveHigh = (state_ff == H_BIT && cnt_ff == lowLen) ||
                     (state_ff == H_HOLD && cnt_ff == swbd_pkg::HOST_SYNC_HOLD);
  assign link.hostOe = driveLow | driveHigh;
  assign link.hostOut = driveHigh;
  assign reqReady = (state_ff == H_IDLE);
  assign respValid = respValid_ff;
  assign respData = resp_ff;

  // ==========================================================================
  // Transfer sequencer.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= H_IDLE;
      cnt_ff <= '0;
      bitsLeft_ff <= '0;
      sending_ff <= 1'b0;
      shift_ff <= '0;
      rx_ff <= '0;
      respValid_ff <= 1'b0;
      resp_ff <= '0;
    end else if (ce) begin
      respValid_ff <= 1'b0;
      cnt_ff <= cnt_ff + 10'h001;
      unique case (state_ff)
        H_IDLE: begin
          cnt_ff <= '0;
          if (reqValid) begin
            shift_ff <= reqData;
            bitsLeft_ff <= reqBits;
            sending_ff <= (reqKind == swbd_pkg::KIND_SEND);
            rx_ff <= '0;
            if (reqKind == swbd_pkg::KIND_SYNC) begin
              state_ff <= H_HOLD;
            end else if (reqBits != 5'h00) begin
              state_ff <= H_BIT;
            end
          end
        end
        H_BIT: begin
          if (!sending_ff && cnt_ff == swbd_pkg::HOST_RX_SAMPLE) begin
            rx_ff <= {rx_ff[22:0], pinSync_ff};
          end
          if (cnt_ff == swbd_pkg::HOST_PERIOD - 10'h001) begin
            cnt_ff <= '0;
            shift_ff <= {shift_ff[22:0], 1'b0};
            bitsLeft_ff <= bitsLeft_ff - 5'h01;
            if (bitsLeft_ff == 5'h01) begin
              state_ff <= H_IDLE;
              respValid_ff <= 1'b1;
              resp_ff <= rx_ff;
            end
          end
        end
        H_HOLD: begin
          if (cnt_ff == swbd_pkg::HOST_SYNC_HOLD) begin
            state_ff <= H_MEAS;
            cnt_ff <= '0;
            rx_ff <= '0;
          end
        end
        H_MEAS: begin
          if (cnt_ff > swbd_pkg::HOST_SYNC_LAT && !pinSync_ff) begin
            rx_ff <= rx_ff + 24'h000001;
          end
          if ((rx_ff != 24'h000000 && pinSync_ff) || cnt_ff == swbd_pkg::HOST_SYNC_WAIT) begin
            state_ff <= H_IDLE;
            respValid_ff <= 1'b1;
            resp_ff <= rx_ff;
          end
        end
      endcase
    end
  end

endmodule : swbd_host

// File: verif/swbd_link_chk.sv
`timescale 1ns/1ps
module swbd_link_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hostOut,
  input wire logic hostOe,
  input wire logic devOut,
  input wire logic devOe,
  input wire logic level
);
  // ==================================
  // Wire timing checks.
  logic devLow;
  logic hostLow;
  logic [9:0] lowCnt_ff;
  logic [9:0] gap_ff;
  assign devLow = devOe && !devOut;
  assign hostLow = hostOe && !hostOut;
  always_ff @(posedge clk) begin
    lowCnt_ff <= (devLow && nrst) ? lowCnt_ff + 10'h001 : 10'h000;
  end
  always_ff @(posedge clk) begin
    gap_ff <= !nrst ? 10'h3ff : $rose(hostLow) ? 10'h001 : gap_ff + {9'h000, gap_ff != 10'h3ff};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence syncEnd;
    $fell(hostLow) && gap_ff >= 10'h080;
  endsequence
  sequence devReply;
    ##[14:24] devLow;
  endsequence
  chk_sync_reply: assert property (syncEnd |-> devReply)
    else $error("sync reply late");
  chk_zero_low: assert property ($fell(devLow) |-> lowCnt_ff == 10'h00d || lowCnt_ff == 10'h080)
    else $error("low length wrong");
  chk_speedup_after: assert property ($fell(devLow) |-> devOe && devOut && level)
    else $error("no speedup");
  chk_speedup_one: assert property (devOe && devOut |=> !devOe)
    else $error("speedup too long");
  chk_idle_quiet: assert property (gap_ff >= 10'h200 |-> !devOe)
    else $error("drive after timeout");
  chk_bit_gap: assert property ($rose(hostLow) |-> gap_ff >= 10'h010)
    else $error("bit too short");
  chk_host_first: assert property ($rose(devOe) |-> gap_ff >= 10'h001 && gap_ff <= 10'h0c8)
    else $error("drive without host edge");
  chk_zero_start: assert property ($rose(devLow) && gap_ff < 10'h040 |-> gap_ff inside {[1:6]})
    else $error("reply start wrong");
endmodule : swbd_link_chk

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ==================================
  // Stimulus and checks.
  typedef struct packed {logic [7:0] c; logic [4:0] nf; logic [23:0] fd;
    logic [4:0] nr; logic [23:0] ex;} swbd_row_type;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic reqValid = 1'b0;
  logic [1:0] reqKind = 2'h0;
  logic [4:0] reqBits = 5'h08;
  logic [23:0] reqData = 24'h000000;
  logic stopMode = 1'b0;
  logic waitMode = 1'b0;
  logic fetchValid = 1'b0;
  logic [15:0] fetchAddr = 16'h0000;
  logic sawHit = 1'b0;
  logic sawStep = 1'b0;
  logic bkptHit;
  logic sawWake = 1'b0;
  logic reqReady, respValid, wakeReq, oscKeep, wdogHold, haltedActive, stepPulse;
  logic memReq, memWe, regWe;
  logic [23:0] respData, wrSeen;
  logic [18:0] regSeen;
  logic [15:0] memAddr, regWdata;
  logic [7:0] memWdata;
  logic [2:0] regIdx;
  int errors = 0;
  int n_compared = 0;
  swbd_row_type rows[14] = '{
    '{8'he4, 5'h00, 24'h0, 5'h08, 24'h00},
    '{8'hc4, 5'h08, 24'h800000, 5'h00, 24'h0},
    '{8'he4, 5'h00, 24'h0, 5'h08, 24'h80},
    '{8'h90, 5'h00, 24'h0, 5'h00, 24'h0},
    '{8'he4, 5'h00, 24'h0, 5'h08, 24'hc0},
    '{8'hc0, 5'h18, 24'h1234a5, 5'h00, 24'h0},
    '{8'he0, 5'h10, 24'h123400, 5'h08, 24'h08},
    '{8'he8, 5'h00, 24'h0, 5'h10, 24'hc008},
    '{8'hc2, 5'h10, 24'h200000, 5'h00, 24'h0},
    '{8'h4b, 5'h10, 24'hbeef00, 5'h00, 24'h0},
    '{8'h6a, 5'h00, 24'h0, 5'h10, 24'h5a02},
    '{8'h08, 5'h00, 24'h0, 5'h00, 24'h0},
    '{8'h6a, 5'h00, 24'h0, 5'h10, 24'hffff},
    '{8'he2, 5'h00, 24'h0, 5'h10, 24'h2000}};
  swbd_link_if link();
  swbd_device i_swbd_device(.clk, .ce(1'b1), .nrst, .link(link.device), .altTick(1'b0), .stopMode,
    .waitMode, .wakeReq, .oscKeep, .wdogHold, .haltedActive, .goPulse(), .stepPulse,
    .stepDone(stepPulse), .fetchValid, .fetchAddr, .bkptHit, .memReq, .memWe,
    .memAddr, .memWdata, .memAck(memReq), .memRdata(memAddr[7:0] ^ 8'h3c), .regWe, .regIdx,
    .regWdata, .regRdata({8'h5a, 5'h00, regIdx}));
  swbd_host i_swbd_host(.clk, .ce(1'b1), .nrst, .link(link.host), .reqValid, .reqReady, .reqKind,
    .reqBits, .reqData, .respValid, .respData);
  swbd_link_chk i_swbd_link_chk(.clk, .nrst, .hostOut(link.hostOut), .hostOe(link.hostOe),
    .devOut(link.devOut), .devOe(link.devOe), .level(link.level));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (memReq && memWe) wrSeen <= {memAddr, memWdata};
    if (regWe) regSeen <= {regIdx, regWdata};
    if (wakeReq) sawWake <= 1'b1;
    if (bkptHit) sawHit <= 1'b1;
    if (stepPulse) sawStep <= 1'b1;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] ex);
    n_compared++;
    if (got !== ex) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask : chk
  task automatic xfer(input logic [1:0] k, input logic [4:0] n, input logic [23:0] d);
    @(negedge clk);
    reqKind = k;
    reqBits = n;
    reqData = d;
    reqValid = 1'b1;
    @(negedge clk);
    reqValid = 1'b0;
    for (int i = 0; i < 2000 && respValid !== 1'b1; i++) @(negedge clk);
  endtask : xfer
  task automatic run(input swbd_row_type r);
    xfer(swbd_pkg::KIND_SEND, 5'h08, {r.c, 16'h0000});
    if (r.nf != 5'h00) xfer(swbd_pkg::KIND_SEND, r.nf, r.fd);
    if (r.nr != 5'h00) begin
      repeat (20) @(negedge clk);
      xfer(swbd_pkg::KIND_RECV, r.nr, 24'h000000);
      chk(respData & ((24'h000001 << r.nr) - 24'h000001), r.ex);
    end
    repeat (20) @(negedge clk);
  endtask : run
  task automatic conclude();
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  initial begin
    #2000000;
    errors++;
    conclude();
  end
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (5) @(negedge clk);
    foreach (rows[i]) run(rows[i]);
    chk(wrSeen, 24'h1234a5);
    chk({5'h00, regSeen}, 24'h03beef);
    xfer(swbd_pkg::KIND_SYNC, 5'h01, 24'h000000);
    chk(respData, 24'h000080);
    xfer(swbd_pkg::KIND_SEND, 5'h08, 24'hc40000);
    repeat (600) @(negedge clk);
    run(swbd_row_type'{8'he4, 5'h00, 24'h0, 5'h08, 24'h80});
    waitMode = 1'b1;
    run(swbd_row_type'{8'h90, 5'h00, 24'h0, 5'h00, 24'h0});
    chk({20'h0, sawWake, haltedActive, wdogHold, oscKeep}, 24'h00000f);
    waitMode = 1'b0;
    stopMode = 1'b1;
    run(swbd_row_type'{8'he4, 5'h00, 24'h0, 5'h08, 24'hc2});
    run(swbd_row_type'{8'hc4, 5'h08, 24'ha00000, 5'h00, 24'h0});
    run(swbd_row_type'{8'h10, 5'h00, 24'h0, 5'h00, 24'h0});
    run(swbd_row_type'{8'he4, 5'h00, 24'h0, 5'h08, 24'he2});
    run(swbd_row_type'{8'h08, 5'h00, 24'h0, 5'h00, 24'h0});
    fetchAddr = 16'h2000;
    fetchValid = 1'b1;
    @(negedge clk);
    fetchValid = 1'b0;
    @(negedge clk);
    chk({21'h0, sawStep, sawHit, haltedActive}, 24'h000007);
    conclude();
  end
endmodule : tb_top
